// *** msp_pkg.sv ***
// Package of constants for the modem serial port control block.
// Assumes a single system clock; all pins are sampled in that domain.
package msp_pkg;
  // Register offsets on the documented register port.
  localparam logic [7:0] MSP_OFF_CTRL = 8'h00;
  localparam logic [7:0] MSP_OFF_CSR = 8'h04;
  localparam logic [7:0] MSP_OFF_TX_DATA_REG = 8'h10;
  localparam logic [7:0] MSP_OFF_RX_DATA_REG = 8'h20;
  localparam logic [7:0] MSP_OFF_UPD = 8'h24;
  // Field positions in the control register.
  localparam int MSP_CR_RX_ORDER = 24;
  localparam int MSP_CR_PIN_A = 22;
  localparam int MSP_CR_PIN_B = 20;
  localparam int MSP_CR_A_OUT = 19;
  localparam int MSP_CR_B_OUT = 18;
  localparam int MSP_CR_TIE = 17;
  localparam int MSP_CR_RIE = 16;
  localparam int MSP_CR_FRAME = 12;
  localparam int MSP_CR_VALID = 8;
  localparam int MSP_CR_FS_TYPE = 7;
  localparam int MSP_CR_FS_POL = 6;
  localparam int MSP_CR_ISDN = 5;
  localparam int MSP_CR_BYTE = 4;
  localparam int MSP_CR_THR = 0;
  // Field positions in the control/status register.
  localparam int MSP_CSR_TEST = 30;
  localparam int MSP_CSR_CDE = 29;
  localparam int MSP_CSR_HALVE = 28;
  localparam int MSP_CSR_SLP = 27;
  localparam int MSP_CSR_UR_CLR = 21;
  localparam int MSP_CSR_OR_CLR = 20;
  localparam int MSP_CSR_FE_CLR = 19;
  localparam int MSP_CSR_CD_CLR = 18;
  localparam int MSP_CSR_FREE = 12;
  localparam int MSP_CSR_READY = 8;
  localparam int MSP_CSR_REFILL = 7;
  localparam int MSP_CSR_RXRDY = 6;
  localparam int MSP_CSR_UNDER = 5;
  localparam int MSP_CSR_OVER = 4;
  localparam int MSP_CSR_FERR = 3;
  localparam int MSP_CSR_CHG = 2;
  localparam int MSP_CSR_PA_IN = 1;
  localparam int MSP_CSR_PB_IN = 0;
  // Writable masks and reset values.
  localparam logic [31:0] MSP_CTRL_MASK = 32'h01FF_FFFF;
  localparam logic [31:0] MSP_CTRL_RESET = 32'h00F0_0000;
  localparam logic [31:0] MSP_CFG_MASK = 32'hF800_0000;
  localparam logic [31:0] MSP_CFG_RESET = 32'h0000_0000;
  // Serial framing constants.
  localparam logic [3:0] MSP_LAST_BIT = 4'hF;
  localparam logic [4:0] MSP_SLOTS_MAX = 5'h10;
  localparam int MSP_FIFO_WIDTH = 32;
  localparam int MSP_FIFO_DEPTH = 8;
  typedef enum logic [1:0] {
    MSP_PIN_OUT = 2'b00,
    MSP_PIN_IN = 2'b01,
    MSP_PIN_ALT = 2'b10,
    MSP_PIN_EXT = 2'b11
  } msp_pin_fn_t;
  typedef enum logic [1:0] {
    MSP_TM_NORM0 = 2'b00,
    MSP_TM_NORM1 = 2'b01,
    MSP_TM_REMOTE = 2'b10,
    MSP_TM_LOCAL = 2'b11
  } msp_test_t;
endpackage : msp_pkg

// *** msp_serial_port.sv ***
// Modem serial port: registers, framing, shifters and two word buffers.
// Assumes all pins are synchronous to sys_clk_i, which outruns the link.
`timescale 1ns/1ps
`default_nettype none

module msp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [CW-1:0] count_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push, pop;

  assign in_ready_o = count_o != CW'(DEPTH);
  assign out_valid_o = count_o != '0;
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    next_wr_ptr = push ? PW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = CW'(count_o + CW'(push) - CW'(pop));
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count_o <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count_o <= next_count;
    end
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule : msp_fifo

module msp_serial_port
  import msp_pkg::*;
#(
  parameter int FIFO_DEPTH = MSP_FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic serial_clock_pin_i,
  input wire logic rx_frame_sync_pin_i,
  input wire logic rx_data_pin_i,
  output logic tx_data_pin_o,
  output logic tx_data_pin_oe_n_o,
  input wire logic multi_pin_a_i,
  output logic multi_pin_a_o,
  output logic multi_pin_a_oe_n_o,
  input wire logic multi_pin_b_i,
  output logic multi_pin_b_o,
  output logic multi_pin_b_oe_n_o,
  input wire logic tx_enable_i,
  input wire logic rx_enable_i,
  input wire logic power_down_i,
  output logic isdn_nt_mode_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic change_irq_o
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);
  // Register state.
  logic [31:0] ctrl, cfg, next_ctrl, next_cfg, next_rdata, status_word;
  logic tx_refill, rx_ready, under, over, ferr, chg;
  logic next_refill, next_rx_ready, next_under, next_over, next_ferr;
  logic next_chg, next_pa_o, next_pa_oe_n, next_pb_o, next_pb_oe_n;
  logic next_tx_irq, next_rx_irq, next_chg_irq;
  // Synchronisers and serial state.
  logic clk_s1, clk_s2, clk_s3, pa_s1, pa_s2, pa_s3, pb_s1, pb_s2;
  logic fs_s1, fs_s2, rd_s1, rd_s2;
  logic half_ph, fs_prev, rx_go, framed, rx_have, tx_go, tx_have;
  logic txfs_prev, gen_fs, chg_store;
  logic next_half_ph, next_fs_prev, next_rx_go, next_framed, next_rx_have;
  logic next_tx_go, next_tx_have, next_txfs_prev, next_gen_fs;
  logic next_chg_store, next_tx_out, next_tx_oe_n;
  logic [3:0] rx_bit, rx_slot, tx_bit, tx_slot;
  logic [3:0] next_rx_bit, next_rx_slot, next_tx_bit, next_tx_slot;
  logic [15:0] rx_sr, rx_half, tx_sr, tx_next, tx_last;
  logic [15:0] next_rx_sr, next_rx_half, next_tx_sr, next_tx_next;
  logic [15:0] next_tx_last, rx_sr_new, tx_word;
  // Derived control and events.
  logic [1:0] pin_a_fn, pin_b_fn, test_mode;
  logic [4:0] nslots, vslots;
  logic [3:0] thr, tx_free, rx_avail, rx_pos_bit, rx_pos_slot;
  logic [3:0] tx_pos_bit, tx_pos_slot;
  logic fs_pol, fs_type, rx_order, pd_eff, remote, local_lb;
  logic rx_raw_edge, rx_capture, fs_lvl, fs_start, rx_bit_in, rx_go_now;
  logic tx_edge, txfs_lvl, tx_fs_start, rx_slot_ok, tx_slot_ok;
  logic ev_under, ev_over, ev_ferr, ev_change, rx_push, tx_pop;
  logic tx_push, rx_pop, csr_wr, upd_wr;
  logic [31:0] rx_word, rx_head, tx_head;
  logic [7:0] b0, b1, b2, b3;
  logic tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
  logic [CW-1:0] tx_cnt, rx_cnt;

  msp_fifo #(.WIDTH(MSP_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_tx_buffer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(reg_wdata_i),
    .in_valid_i(tx_push),
    .in_ready_o(tx_in_ready),
    .out_data_o(tx_head),
    .out_valid_o(tx_out_valid),
    .out_ready_i(tx_pop),
    .count_o(tx_cnt)
  );

  msp_fifo #(.WIDTH(MSP_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rx_buffer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(rx_word),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .out_data_o(rx_head),
    .out_valid_o(rx_out_valid),
    .out_ready_i(rx_pop),
    .count_o(rx_cnt)
  );

  assign pin_a_fn = ctrl[MSP_CR_PIN_A +: 2];
  assign pin_b_fn = ctrl[MSP_CR_PIN_B +: 2];
  assign test_mode = cfg[MSP_CSR_TEST +: 2];
  assign remote = test_mode == MSP_TM_REMOTE;
  assign local_lb = test_mode == MSP_TM_LOCAL;
  assign fs_pol = ctrl[MSP_CR_FS_POL];
  assign fs_type = ctrl[MSP_CR_FS_TYPE];
  assign rx_order = ctrl[MSP_CR_RX_ORDER];
  assign thr = ctrl[MSP_CR_THR +: 4];
  assign nslots = ctrl[MSP_CR_FRAME +: 4] == 4'h0 ? MSP_SLOTS_MAX
                  : {1'b0, ctrl[MSP_CR_FRAME +: 4]};
  assign vslots = ctrl[MSP_CR_VALID +: 4] == 4'h0 ? MSP_SLOTS_MAX
                  : {1'b0, ctrl[MSP_CR_VALID +: 4]};
  assign pd_eff = power_down_i & ~cfg[MSP_CSR_SLP];
  assign tx_free = 4'(CW'(FIFO_DEPTH) - tx_cnt);
  assign rx_avail = 4'(rx_cnt);

  // Receive timing: sync, and data outside local loopback, come from the second synchroniser stage; the clock edge also uses the third.
  assign rx_raw_edge = clk_s2 & ~clk_s3;
  assign fs_lvl = fs_s2 ^ fs_pol;
  assign fs_start = rx_raw_edge & fs_lvl & ~fs_prev;
  assign rx_capture = rx_raw_edge
                      & (~cfg[MSP_CSR_HALVE] | half_ph | fs_start);
  assign rx_bit_in = local_lb ? tx_data_pin_o : rd_s2;
  assign rx_pos_bit = fs_start ? 4'h0 : rx_bit;
  assign rx_pos_slot = fs_start ? 4'h0 : rx_slot;
  assign rx_slot_ok = {1'b0, rx_pos_slot} < vslots;
  assign rx_go_now = rx_pos_bit == 4'h0
                     ? rx_enable_i & ~pd_eff & rx_slot_ok : rx_go;
  assign rx_sr_new = rx_order ? {rx_sr[14:0], rx_bit_in}
                     : {rx_bit_in, rx_sr[15:1]};
  // The first byte of a word is its high byte when shifted MSB first.
  assign b0 = rx_order ? rx_half[15:8] : rx_half[7:0];
  assign b1 = rx_order ? rx_half[7:0] : rx_half[15:8];
  assign b2 = rx_order ? rx_sr_new[15:8] : rx_sr_new[7:0];
  assign b3 = rx_order ? rx_sr_new[7:0] : rx_sr_new[15:8];
  assign rx_word = ctrl[MSP_CR_BYTE] ? {b3, b2, b1, b0}
                   : {b0, b1, b2, b3};

  // Transmit timing: pin A clock when selected, else falling serial clock.
  assign tx_edge = pin_a_fn == MSP_PIN_ALT ? pa_s2 & ~pa_s3
                   : clk_s3 & ~clk_s2;
  assign txfs_lvl = pb_s2 ^ fs_pol;
  assign tx_fs_start = tx_edge & (pin_b_fn == MSP_PIN_EXT) & txfs_lvl
                       & ~txfs_prev;
  assign tx_pos_bit = tx_fs_start ? 4'h0 : tx_bit;
  assign tx_pos_slot = tx_fs_start ? 4'h0 : tx_slot;
  assign tx_slot_ok = {1'b0, tx_pos_slot} < vslots;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      {clk_s1, clk_s2, clk_s3, pa_s1, pa_s2, pa_s3} <= 6'h00;
      {pb_s1, pb_s2, fs_s1, fs_s2, rd_s1, rd_s2} <= 6'h00;
    end else begin
      clk_s1 <= serial_clock_pin_i;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      pa_s1 <= multi_pin_a_i;
      pa_s2 <= pa_s1;
      pa_s3 <= pa_s2;
      pb_s1 <= multi_pin_b_i;
      pb_s2 <= pb_s1;
      fs_s1 <= rx_frame_sync_pin_i;
      fs_s2 <= fs_s1;
      rd_s1 <= rx_data_pin_i;
      rd_s2 <= rd_s1;
    end
  end

  always_comb begin
    next_half_ph = half_ph;
    next_fs_prev = fs_prev;
    next_rx_bit = rx_bit;
    next_rx_slot = rx_slot;
    next_rx_sr = rx_sr;
    next_rx_half = rx_half;
    next_rx_have = rx_have;
    next_rx_go = rx_go;
    next_framed = framed;
    next_tx_bit = tx_bit;
    next_tx_slot = tx_slot;
    next_tx_sr = tx_sr;
    next_tx_next = tx_next;
    next_tx_last = tx_last;
    next_tx_have = tx_have;
    next_tx_go = tx_go;
    next_txfs_prev = txfs_prev;
    next_gen_fs = gen_fs;
    next_chg_store = chg_store;
    next_tx_out = tx_data_pin_o;
    next_tx_oe_n = ~(tx_go | remote);
    tx_word = tx_sr;
    {ev_under, ev_over, ev_ferr, ev_change, rx_push, tx_pop} = 6'h00;
    if (rx_raw_edge) begin
      next_fs_prev = fs_lvl;
      next_half_ph = fs_start ? 1'b0 : ~half_ph;
      if (cfg[MSP_CSR_CDE] && pin_a_fn == MSP_PIN_IN) begin
        ev_change = pa_s2 != chg_store;
        next_chg_store = pa_s2;
      end
      if (remote) begin
        next_tx_out = rd_s2;
      end
    end
    if (rx_capture) begin
      if (fs_start) begin
        ev_ferr = framed && (rx_bit != 4'h0 || rx_slot != 4'h0);
        next_framed = 1'b1;
      end else if (framed && rx_bit == 4'h0 && rx_slot == 4'h0) begin
        ev_ferr = 1'b1;
      end else if (framed && rx_slot == 4'h0 && rx_bit != 4'h0) begin
        ev_ferr = fs_type ? ~fs_lvl : (rx_bit == 4'h1) & fs_lvl;
      end
      next_rx_go = rx_go_now;
      if (rx_go_now) begin
        next_rx_sr = rx_sr_new;
        if (rx_pos_bit == MSP_LAST_BIT) begin
          next_rx_have = ~rx_have;
          if (!rx_have) begin
            next_rx_half = rx_sr_new;
          end else if (!remote) begin
            rx_push = rx_in_ready;
            ev_over = ~rx_in_ready;
          end
        end
      end
      next_rx_bit = 4'(rx_pos_bit + 1'b1);
      next_rx_slot = rx_pos_slot;
      if (rx_pos_bit == MSP_LAST_BIT) begin
        next_rx_slot = {1'b0, rx_pos_slot} == nslots - 5'h01 ? 4'h0
                       : 4'(rx_pos_slot + 1'b1);
      end
    end
    if (tx_edge && !remote) begin
      next_txfs_prev = txfs_lvl;
      if (tx_pos_bit == 4'h0) begin
        next_tx_go = tx_enable_i & ~pd_eff & tx_slot_ok;
        if (next_tx_go && tx_have) begin
          tx_word = tx_next;
          next_tx_have = 1'b0;
        end else if (next_tx_go && tx_out_valid) begin
          tx_pop = 1'b1;
          tx_word = tx_head[15:0];
          next_tx_next = tx_head[31:16];
          next_tx_have = 1'b1;
        end else if (next_tx_go) begin
          tx_word = tx_last;
          ev_under = 1'b1;
        end
        next_tx_last = tx_word;
      end
      if (next_tx_go) begin
        next_tx_out = tx_word[15];
        next_tx_sr = {tx_word[14:0], 1'b0};
      end
      next_tx_bit = 4'(tx_pos_bit + 1'b1);
      next_tx_slot = tx_pos_slot;
      if (tx_pos_bit == MSP_LAST_BIT) begin
        next_tx_slot = {1'b0, tx_pos_slot} == nslots - 5'h01 ? 4'h0
                       : 4'(tx_pos_slot + 1'b1);
      end
      next_gen_fs = fs_pol ^ (next_tx_slot == 4'h0
                    && (fs_type || next_tx_bit == 4'h0));
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      {half_ph, fs_prev, rx_go, framed, rx_have, tx_go, tx_have} <= 7'h00;
      {txfs_prev, gen_fs, chg_store} <= 3'h0;
      {rx_bit, rx_slot, tx_bit, tx_slot} <= 16'h0000;
      {rx_sr, rx_half, tx_sr, tx_next, tx_last} <= 80'h0;
      tx_data_pin_o <= 1'b0;
      tx_data_pin_oe_n_o <= 1'b1;
    end else begin
      half_ph <= next_half_ph;
      fs_prev <= next_fs_prev;
      rx_go <= next_rx_go;
      framed <= next_framed;
      rx_have <= next_rx_have;
      tx_go <= next_tx_go;
      tx_have <= next_tx_have;
      txfs_prev <= next_txfs_prev;
      gen_fs <= next_gen_fs;
      chg_store <= next_chg_store;
      rx_bit <= next_rx_bit;
      rx_slot <= next_rx_slot;
      tx_bit <= next_tx_bit;
      tx_slot <= next_tx_slot;
      rx_sr <= next_rx_sr;
      rx_half <= next_rx_half;
      tx_sr <= next_tx_sr;
      tx_next <= next_tx_next;
      tx_last <= next_tx_last;
      tx_data_pin_o <= next_tx_out;
      tx_data_pin_oe_n_o <= next_tx_oe_n;
    end
  end

  // Register port, sticky flags, pins and interrupt outputs.
  assign csr_wr = reg_wr_i && reg_addr_i == MSP_OFF_CSR;
  assign upd_wr = reg_wr_i && reg_addr_i == MSP_OFF_UPD && reg_wdata_i[0];
  assign tx_push = reg_wr_i && reg_addr_i == MSP_OFF_TX_DATA_REG;
  assign rx_pop = upd_wr & rx_out_valid;

  always_comb begin
    status_word = cfg;
    status_word[MSP_CSR_FREE +: 4] = tx_free;
    status_word[MSP_CSR_READY +: 4] = rx_avail;
    status_word[MSP_CSR_REFILL] = tx_refill;
    status_word[MSP_CSR_RXRDY] = rx_ready;
    status_word[MSP_CSR_UNDER] = under;
    status_word[MSP_CSR_OVER] = over;
    status_word[MSP_CSR_FERR] = ferr;
    status_word[MSP_CSR_CHG] = chg;
    status_word[MSP_CSR_PA_IN] = pin_a_fn != MSP_PIN_EXT && pa_s2;
    status_word[MSP_CSR_PB_IN] = pb_s2;
    next_ctrl = ctrl;
    next_cfg = cfg;
    if (reg_wr_i && reg_addr_i == MSP_OFF_CTRL) begin
      next_ctrl = reg_wdata_i & MSP_CTRL_MASK;
    end
    if (csr_wr) begin
      next_cfg = reg_wdata_i & MSP_CFG_MASK;
    end
    next_rdata = 32'h0000_0000;
    if (reg_rd_i) begin
      case (reg_addr_i)
        MSP_OFF_CTRL: next_rdata = ctrl;
        MSP_OFF_CSR: next_rdata = status_word;
        MSP_OFF_RX_DATA_REG: next_rdata = rx_head;
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_under = ev_under
                 | (under & ~(csr_wr & reg_wdata_i[MSP_CSR_UR_CLR]));
    next_over = ev_over
                | (over & ~(csr_wr & reg_wdata_i[MSP_CSR_OR_CLR]));
    next_ferr = ev_ferr
                | (ferr & ~(csr_wr & reg_wdata_i[MSP_CSR_FE_CLR]));
    next_chg = ev_change
               | (chg & ~(csr_wr & reg_wdata_i[MSP_CSR_CD_CLR]));
    next_refill = tx_free > thr ? 1'b1
                  : (tx_free < thr ? 1'b0 : tx_refill);
    next_rx_ready = rx_avail > thr
                    || (rx_ready && !upd_wr);
    if (rx_pop && rx_avail - 4'h1 <= thr) begin
      next_rx_ready = 1'b0;
    end
    next_pa_o = ctrl[MSP_CR_A_OUT];
    next_pa_oe_n = pin_a_fn != MSP_PIN_OUT;
    next_pb_o = pin_b_fn == MSP_PIN_ALT ? gen_fs : ctrl[MSP_CR_B_OUT];
    next_pb_oe_n = pin_b_fn != MSP_PIN_OUT
                   && pin_b_fn != MSP_PIN_ALT;
    next_tx_irq = ctrl[MSP_CR_TIE] & tx_refill & ~remote;
    next_rx_irq = ctrl[MSP_CR_RIE] & (rx_ready | over) & ~remote;
    next_chg_irq = cfg[MSP_CSR_CDE] & chg;
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ctrl <= MSP_CTRL_RESET;
      cfg <= MSP_CFG_RESET;
      reg_rdata_o <= 32'h0000_0000;
      {tx_refill, rx_ready, under, over, ferr, chg} <= 6'h00;
      {multi_pin_a_o, multi_pin_b_o} <= 2'h0;
      {multi_pin_a_oe_n_o, multi_pin_b_oe_n_o} <= 2'h3;
      {isdn_nt_mode_o, tx_irq_o, rx_irq_o, change_irq_o} <= 4'h0;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      reg_rdata_o <= next_rdata;
      tx_refill <= next_refill;
      rx_ready <= next_rx_ready;
      under <= next_under;
      over <= next_over;
      ferr <= next_ferr;
      chg <= next_chg;
      multi_pin_a_o <= next_pa_o;
      multi_pin_a_oe_n_o <= next_pa_oe_n;
      multi_pin_b_o <= next_pb_o;
      multi_pin_b_oe_n_o <= next_pb_oe_n;
      isdn_nt_mode_o <= ctrl[MSP_CR_ISDN];
      tx_irq_o <= next_tx_irq;
      rx_irq_o <= next_rx_irq;
      change_irq_o <= next_chg_irq;
    end
  end

  a_tx_irq_cause: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) tx_irq_o |-> $past(ctrl[MSP_CR_TIE] && tx_refill))
    else $error("Transmit interrupt without enable and refill flag.");
  a_rx_irq_cause: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) rx_irq_o |-> $past(ctrl[MSP_CR_RIE]))
    else $error("Receive interrupt raised while disabled.");
  a_action_read_zero: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) reg_rd_i && reg_addr_i == MSP_OFF_CSR
    |=> reg_rdata_o[MSP_CSR_CD_CLR +: 4] == 4'h0)
    else $error("Action bits did not read zero.");
  a_pin_a_drive: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) pin_a_fn == MSP_PIN_OUT |=> !multi_pin_a_oe_n_o
    && multi_pin_a_o == $past(ctrl[MSP_CR_A_OUT]))
    else $error("Pin A does not follow its write bit.");
  a_pin_b_float: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) pin_b_fn == MSP_PIN_EXT |=> multi_pin_b_oe_n_o)
    else $error("Pin B driven while set as sync input.");
  a_refill_set: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) tx_free > thr |=> tx_refill)
    else $error("Refill flag not set above threshold.");
  a_under_flag: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) ev_under |=> under)
    else $error("Underrun event lost.");
  a_over_flag: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) ev_over |=> over ##1 (over || $past(csr_wr)))
    else $error("Overrun event lost.");
  a_change_flag: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) ev_change |=> chg)
    else $error("Change detect event lost.");
  a_ready_hold: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) rx_ready && !upd_wr |=> rx_ready)
    else $error("Ready flag cleared without update write.");
endmodule : msp_serial_port

`default_nettype wire

// *** msp_afe_model.sv ***
// Behavioural front end that sends framed words to the receive side.
// Assumes the bench clock; the link clock runs only inside frames.
`timescale 1ns/1ps
`default_nettype none
module msp_afe_model (
  input wire logic sys_clk_i,
  output logic sclk_o,
  output logic sync_o,
  output logic sdata_o
);
  initial begin
    sclk_o = 1'b0;
    sync_o = 1'b0;
    sdata_o = 1'b0;
  end
  task automatic send(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      sync_o = (i == 0);
      sdata_o = w[i];
      repeat (4) @(negedge sys_clk_i);
      sclk_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      sclk_o = 1'b0;
    end
    sync_o = 1'b0;
    sdata_o = ~sdata_o;
  endtask : send
endmodule : msp_afe_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the modem serial port.
// Assumes the front-end model drives the receive pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
  import msp_pkg::*;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0, rd_d = 1'b0, pa_i = 1'b0, pb_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, e, seed = 32'h0731C247;
  logic [31:0] exp_q[$], words[9];
  logic pa_o, pa_oe_n, pb_o, pb_oe_n, isdn, tx_irq, rx_irq, sclk, sync, sd;
  logic tx_en = 1'b0, tx_d, tx_oe_n, chg_irq;
  logic [31:0] tx_w;
  int n_mismatch = 0, checks = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) rd_d <= reg_rd_i;
  always @(negedge sys_clk_i) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK("reg_rdata_o", e, reg_rdata_o)
    end
  end
  msp_afe_model afe_u (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .sync_o(sync),
    .sdata_o(sd));
  msp_serial_port dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .serial_clock_pin_i(sclk), .rx_frame_sync_pin_i(sync),
    .rx_data_pin_i(sd), .tx_data_pin_o(tx_d), .tx_data_pin_oe_n_o(tx_oe_n),
    .multi_pin_a_i(pa_i), .multi_pin_a_o(pa_o), .multi_pin_a_oe_n_o(pa_oe_n),
    .multi_pin_b_i(pb_i), .multi_pin_b_o(pb_o), .multi_pin_b_oe_n_o(pb_oe_n),
    .tx_enable_i(tx_en), .rx_enable_i(1'b1), .power_down_i(1'b0),
    .isdn_nt_mode_o(isdn), .tx_irq_o(tx_irq), .rx_irq_o(rx_irq),
    .change_irq_o(chg_irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_i = 1'b0;
    @(negedge sys_clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_i = 1'b0;
    @(negedge sys_clk_i);
  endtask : rd
  task automatic complete_run();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge sys_clk_i);
    sys_rst_i = 1'b0;
    rd(MSP_OFF_CTRL, MSP_CTRL_RESET);
    rd(MSP_OFF_CSR, 32'h0000_8080);
    rd(8'h08, 32'h0);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      pa_i = seed[3];
      pb_i = seed[4];
      wr(MSP_OFF_CTRL, {8'h0, k[1:0], k[1:0], seed[1:0], 12'h0, seed[2], 5'h0});
      @(negedge sys_clk_i);
      `CHK("pin_a_oe", k != 0, pa_oe_n)
      `CHK("pin_b_oe", !(k == 0 || k == 2), pb_oe_n)
      if (k == 0) `CHK("pins", seed[1:0], {pa_o, pb_o})
      `CHK("isdn", seed[2], isdn)
      if (k == 1) rd(MSP_OFF_CSR, {30'h2020, seed[3], seed[4]});
    end
    pa_i = 1'b0;
    pb_i = 1'b0;
    wr(MSP_OFF_CTRL, 32'h00F0_0009);
    for (int k = 0; k < 9; k++) wr(MSP_OFF_TX_DATA_REG, xs(k + 1));
    rd(MSP_OFF_CSR, 32'h0);
    wr(MSP_OFF_CTRL, 32'h00F3_2212);
    rd(MSP_OFF_CTRL, 32'h00F3_2212);
    for (int k = 0; k < 9; k++) begin
      seed = xs(seed);
      words[k] = seed;
      afe_u.send(seed);
    end
    repeat (8) @(negedge sys_clk_i);
    rd(MSP_OFF_CSR, 32'h0000_0850);
    `CHK("irqs", 2'b01, {tx_irq, rx_irq})
    for (int k = 0; k < 8; k++) begin
      rd(MSP_OFF_RX_DATA_REG, words[k]);
      wr(MSP_OFF_UPD, 32'h1);
    end
    rd(MSP_OFF_CSR, 32'h0000_0010);
    wr(MSP_OFF_CSR, 32'h0010_0000);
    rd(MSP_OFF_CSR, 32'h0);
    // Pin A as input with change detect, transmitter on, bytes reversed.
    wr(MSP_OFF_CTRL, 32'h0053_2202);
    wr(MSP_OFF_CSR, 32'h2000_0000);
    pa_i = 1'b1;
    tx_en = 1'b1;
    seed = xs(seed);
    afe_u.send(seed);
    repeat (8) @(negedge sys_clk_i);
    tx_w = xs(32'h0000_0001);
    `CHK("chg_irq", 1'b1, chg_irq)
    `CHK("tx_oe_n", 1'b0, tx_oe_n)
    `CHK("tx_data", tx_w[16], tx_d)
    rd(MSP_OFF_CSR, 32'h2000_1106);
    rd(MSP_OFF_RX_DATA_REG, {seed[7:0], seed[15:8], seed[23:16], seed[31:24]});
    wr(MSP_OFF_CSR, 32'h2004_0000);
    rd(MSP_OFF_CSR, 32'h2000_1102);
    `CHK("chg_irq", 1'b0, chg_irq)
    complete_run();
  end
endmodule : tb
`default_nettype wire
